// ---- hdl/psia_top.sv ----
// psia_top: program counter, upper-bits latch, return stack and indirect
// data addressing of a small 8-bit core, with an APB register window.
// assumes: the core sequencer issues one command per clock; data memory
// answers a read in the same cycle its address is presented.
//
// Notes on behaviour
// - thirteen-bit counter, low byte read and written
// - upper counter bits never readable by software
// - every reset clears the upper bits
// - low-byte write loads upper bits from latch
// - call/goto: eleven target bits, latch page bits
// - 8K-word space, jumps stay in 2K page
// - latch bit four ignored when forming addresses
// - eight by thirteen stack, pointer hidden
// - call or interrupt vector pushes whole counter
// - returns pop the stack into the counter
// - push and pop leave latch untouched
// - stack wraps, ninth push overwrites the first
// - no overflow, underflow flags or push instructions
// - indirect port accesses the pointed register
// - self-pointing read gives zero, write ignored
// - effective address is bank bit over pointer
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module psia_top #(
    parameter logic [12:0] INT_VECTOR = psia_pkg::INT_VECTOR_DEFAULT,
    parameter logic IGNORE_PAGE_HI = 1'b1,
    parameter int STACK_DEPTH = psia_pkg::STACK_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core sequencer
    input wire psia_pkg::psia_seq_cmd_t seqCmd,
    input wire psia_pkg::psia_data_req_t dataReq,
    // program memory address bus
    output logic [12:0] progAddr,
    // data memory bus
    output psia_pkg::psia_data_req_t memAccess,
    input wire logic [7:0] memRdata,
    // read answer to the core
    output logic [7:0] readData,
    output logic readValid
);

    // ------------------------------------------------------------
    // register select codes
    // ------------------------------------------------------------

    // decoded register, shared by read and write paths
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_PC_LOW = 3'h1,
        SEL_LATCH = 3'h3,
        SEL_POINTER = 3'h2,
        SEL_BANK = 3'h6
    } psia_sel_t;

    // one decode used by both the read mux and the write strobe
    function automatic psia_sel_t decode_reg(input logic [11:0] addr);
        psia_sel_t sel;
        sel = SEL_NONE;
        unique case (addr)
            psia_pkg::OFF_PC_LOW: sel = SEL_PC_LOW;
            psia_pkg::OFF_UPPER_LATCH: sel = SEL_LATCH;
            psia_pkg::OFF_FILE_POINTER: sel = SEL_POINTER;
            psia_pkg::OFF_BANK: sel = SEL_BANK;
            default: sel = SEL_NONE; // unmapped word
        endcase
        return sel;
    endfunction

    // upper counter bits taken from the latch, with bit four masked
    function automatic logic [4:0] latch_upper(input logic [4:0] latch);
        logic [4:0] upper;
        upper = latch;
        upper[psia_pkg::LATCH_PAGE_HI] = latch[psia_pkg::LATCH_PAGE_HI] & ~IGNORE_PAGE_HI;
        return upper;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------

    logic [12:0] pc; // whole counter; only its low byte is visible
    logic [12:0] next_pc;
    logic [4:0] upperLatch; // staging bits for the counter top
    logic [4:0] next_upperLatch;
    logic [7:0] filePointer; // indirect pointer
    logic [7:0] next_filePointer;
    logic indirectBankBit; // ninth indirect address bit
    logic next_indirectBankBit;

    // bus decode
    psia_sel_t busSel; // register under the current address
    logic busAccess; // access phase of any transfer
    logic busWrite; // write taking effect this edge

    // stack hookup
    logic stackPush;
    logic stackPop;
    logic [12:0] stackPushValue;
    logic [12:0] stackTop;

    // data path
    logic [8:0] effectiveAddr;
    logic nullAccess;
    psia_pkg::psia_data_req_t next_memAccess;
    logic readPending; // a real read is on the memory bus
    logic next_readPending;
    logic nullPending; // a self-pointing read waits to answer
    logic next_nullPending;
    logic [7:0] next_readData;
    logic next_readValid;

    // pc plus one, wraps within the 13-bit space
    logic [12:0] pcPlusOne;
    assign pcPlusOne = pc + 13'h0001;

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------

    // zero-wait slave: every access phase completes at once, so no
    // transfer ever stalls and the read mux can stay combinational
    assign pready = 1'b1;
    assign busSel = decode_reg(paddr);
    assign busAccess = psel && penable;
    assign busWrite = busAccess && pwrite && (busSel != SEL_NONE);

    // unmapped words answer with an error and change nothing
    assign pslverr = busAccess && (busSel == SEL_NONE);

    // read mux; the counter's upper bits have no path out
    always_comb begin
        prdata = 32'h0000_0000;
        if (busAccess && !pwrite) begin
            unique case (busSel)
                SEL_PC_LOW: prdata[7:0] = pc[7:0];
                SEL_LATCH: prdata[4:0] = upperLatch;
                SEL_POINTER: prdata[7:0] = filePointer;
                SEL_BANK: prdata[psia_pkg::BANK_FIELD_POS] = indirectBankBit;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------

    // next counter value; a core command outranks a bus write to the
    // low byte in the same cycle, because the core owns program flow
    always_comb begin
        next_pc = pc;
        stackPush = 1'b0;
        stackPop = 1'b0;
        stackPushValue = pcPlusOne;
        unique case (seqCmd.op)
            psia_pkg::OP_IDLE: begin
                if (busWrite && busSel == SEL_PC_LOW) begin
                    // bus write to the low byte pulls the latch in
                    next_pc = {latch_upper(upperLatch), pwdata[7:0]};
                end
            end
            psia_pkg::OP_STEP: begin
                // plain fetch advance
                next_pc = pcPlusOne;
            end
            psia_pkg::OP_GOTO: begin
                // page bits from the latch, offset from the opcode
                next_pc = {2'(latch_upper(upperLatch) >> psia_pkg::LATCH_PAGE_LO), seqCmd.target};
            end
            psia_pkg::OP_CALL: begin
                // return address is the word after the call
                stackPush = 1'b1;
                stackPushValue = pcPlusOne;
                next_pc = {2'(latch_upper(upperLatch) >> psia_pkg::LATCH_PAGE_LO), seqCmd.target};
            end
            psia_pkg::OP_RETURN: begin
                // covers return, return_with_literal, return_from_interrupt
                stackPop = 1'b1;
                next_pc = stackTop;
            end
            psia_pkg::OP_VECTOR: begin
                // the interrupted instruction resumes on return
                stackPush = 1'b1;
                stackPushValue = pc;
                next_pc = INT_VECTOR;
            end
            psia_pkg::OP_WRITE_LOW: begin
                // instruction writes the low byte, e.g. a computed jump;
                // upper bits come from the latch, not from any carry
                next_pc = {latch_upper(upperLatch), seqCmd.low};
            end
            default: begin
                // undefined op code: hold
                next_pc = pc;
            end
        endcase
    end

    // register the counter; reset clears all of it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pc <= psia_pkg::RST_PC;
        end else begin
            pc <= next_pc;
        end
    end

    // program address bus is the counter flop itself
    assign progAddr = pc;

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------

    // latch changes only on a bus write; stack traffic never touches it
    always_comb begin
        next_upperLatch = upperLatch;
        next_filePointer = filePointer;
        next_indirectBankBit = indirectBankBit;
        if (busWrite) begin
            unique case (busSel)
                SEL_LATCH: next_upperLatch = pwdata[4:0];
                SEL_POINTER: next_filePointer = pwdata[7:0];
                SEL_BANK: next_indirectBankBit = pwdata[psia_pkg::BANK_FIELD_POS];
                default: next_upperLatch = upperLatch; // low byte handled above
            endcase
        end
    end

    // register the software-visible state
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            upperLatch <= psia_pkg::RST_LATCH;
            filePointer <= psia_pkg::RST_FILE_POINTER;
            indirectBankBit <= psia_pkg::RST_BANK;
        end else begin
            upperLatch <= next_upperLatch;
            filePointer <= next_filePointer;
            indirectBankBit <= next_indirectBankBit;
        end
    end

    // ------------------------------------------------------------
    // return stack
    // ------------------------------------------------------------

    // fixed-depth circle; no flags leave it
    psia_return_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(psia_pkg::PC_WIDTH)
    ) returnStack (
        .clock(clock),
        .reset(reset),
        .push(stackPush),
        .pop(stackPop),
        .pushValue(stackPushValue),
        .topValue(stackTop)
    );

    // ------------------------------------------------------------
    // indirect data addressing
    // ------------------------------------------------------------

    // resolve the data address through the pointer
    psia_indirect indirect (
        .directAddr(dataReq.addr),
        .filePointer(filePointer),
        .indirectBankBit(indirectBankBit),
        .effectiveAddr(effectiveAddr),
        .nullAccess(nullAccess)
    );

    // memory request: a self-pointing access never reaches memory,
    // so its write is dropped while the core may still update flags
    always_comb begin
        next_memAccess = '0;
        next_readPending = 1'b0;
        next_nullPending = 1'b0;
        if (dataReq.valid) begin
            if (nullAccess) begin
                next_nullPending = !dataReq.write;
            end else begin
                next_memAccess.valid = 1'b1;
                next_memAccess.write = dataReq.write;
                next_memAccess.addr = effectiveAddr;
                next_memAccess.wdata = dataReq.wdata;
                next_readPending = !dataReq.write;
            end
        end
    end

    // read answer one cycle after the memory saw the address
    always_comb begin
        next_readValid = readPending || nullPending;
        next_readData = readData;
        if (nullPending) begin
            next_readData = psia_pkg::NULL_READ_VALUE;
        end else if (readPending) begin
            next_readData = memRdata;
        end
    end

    // register the data path
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            memAccess <= '0;
            readPending <= 1'b0;
            nullPending <= 1'b0;
            readData <= 8'h00;
            readValid <= 1'b0;
        end else begin
            memAccess <= next_memAccess;
            readPending <= next_readPending;
            nullPending <= next_nullPending;
            readData <= next_readData;
            readValid <= next_readValid;
        end
    end

endmodule
`default_nettype wire

// ---- hdl/psia_pkg.sv ----
// psia_pkg: constants, command codes and carrier structs shared by the
// program-flow and indirect-addressing block and its helpers.
// assumes: nothing; every user writes psia_pkg::name.
package psia_pkg;

    // widths of the program counter and its parts
    localparam int PC_WIDTH = 13;
    localparam int LOW_WIDTH = 8;
    localparam int UPPER_WIDTH = 5;
    localparam int TARGET_WIDTH = 11;
    localparam int STACK_DEPTH = 8;
    localparam int DATA_ADDR_WIDTH = 9;
    localparam int APB_ADDR_WIDTH = 12;

    // register byte offsets on the bus
    localparam logic [11:0] OFF_PC_LOW = 12'h000;
    localparam logic [11:0] OFF_UPPER_LATCH = 12'h004;
    localparam logic [11:0] OFF_FILE_POINTER = 12'h008;
    localparam logic [11:0] OFF_BANK = 12'h00C;

    // field positions
    localparam int LATCH_PAGE_LO = 3;
    localparam int LATCH_PAGE_HI = 4;
    localparam int BANK_FIELD_POS = 7;

    // reset values
    localparam logic [12:0] RST_PC = 13'h0000;
    localparam logic [4:0] RST_LATCH = 5'h00;
    localparam logic [7:0] RST_FILE_POINTER = 8'h00;
    localparam logic RST_BANK = 1'b0;
    localparam logic [12:0] INT_VECTOR_DEFAULT = 13'h0004;

    // indirect port decode and its self-access answer
    localparam logic [6:0] INDIRECT_PORT_INDEX = 7'h00;
    localparam logic [7:0] NULL_READ_VALUE = 8'h00;

    // sequencer commands, gray-coded along fetch, goto, call, return
    typedef enum logic [2:0] {
        OP_IDLE = 3'h0,
        OP_STEP = 3'h1,
        OP_GOTO = 3'h3,
        OP_CALL = 3'h2,
        OP_RETURN = 3'h6,
        OP_VECTOR = 3'h7,
        OP_WRITE_LOW = 3'h5
    } psia_op_t;

    // one command from the core sequencer per cycle
    typedef struct packed {
        psia_op_t op;
        logic [10:0] target;
        logic [7:0] low;
    } psia_seq_cmd_t;

    // one data access, used for the request and the memory side
    typedef struct packed {
        logic valid;
        logic write;
        logic [8:0] addr;
        logic [7:0] wdata;
    } psia_data_req_t;

endpackage

// ---- hdl/psia_return_stack.sv ----
// psia_return_stack: circular return-address stack in flip-flops.
// assumes: push and pop never come in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module psia_return_stack #(
    parameter int DEPTH = psia_pkg::STACK_DEPTH,
    parameter int WIDTH = psia_pkg::PC_WIDTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // stack operations
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] pushValue,
    output logic [WIDTH-1:0] topValue
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] entries [DEPTH];
    logic [WIDTH-1:0] next_entries [DEPTH];
    logic [PW-1:0] pointer; // next free slot, hidden from software
    logic [PW-1:0] next_pointer;

    // the newest entry sits just below the pointer
    assign topValue = entries[pointer - PW'(1)];

    // pointer wraps: the ninth push lands on the first slot
    always_comb begin
        next_entries = entries;
        next_pointer = pointer;
        if (push) begin
            next_entries[pointer] = pushValue;
            next_pointer = pointer + PW'(1);
        end else if (pop) begin
            // no underflow flag: popping past empty keeps wrapping
            next_pointer = pointer - PW'(1);
        end
    end

    // register stack state
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pointer <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                entries[i] <= '0;
            end
        end else begin
            pointer <= next_pointer;
            entries <= next_entries;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/psia_indirect.sv ----
// psia_indirect: turns a data address into the effective address,
// resolving the indirect port through the file pointer and bank bit.
// assumes: purely combinational use by the top module.
`timescale 1ns/1ps
`default_nettype none
module psia_indirect (
    // access from the instruction
    input wire logic [8:0] directAddr,
    // pointer state
    input wire logic [7:0] filePointer,
    input wire logic indirectBankBit,
    // resolved access
    output logic [8:0] effectiveAddr,
    output logic nullAccess
);
    logic isIndirect;

    // the port has no storage of its own; it is a window
    assign isIndirect = (directAddr[6:0] == psia_pkg::INDIRECT_PORT_INDEX);

    // bank bit on top of the pointer gives nine bits
    always_comb begin
        effectiveAddr = directAddr;
        if (isIndirect) begin
            effectiveAddr = {indirectBankBit, filePointer};
        end
    end

    // a pointer of zero points back at the port itself
    assign nullAccess = isIndirect && (filePointer == 8'h00);
endmodule
`default_nettype wire

// ---- sim/psia_top_props.sv ----
// psia_top_props: concurrent checks on the ports of psia_top.
// assumes: bound to every psia_top instance; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module psia_top_props #(
    parameter logic [12:0] INT_VECTOR = psia_pkg::INT_VECTOR_DEFAULT,
    parameter logic IGNORE_PAGE_HI = 1'b1
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register bus
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    // core side
    input wire psia_pkg::psia_seq_cmd_t seqCmd,
    input wire psia_pkg::psia_data_req_t dataReq,
    input wire logic [12:0] progAddr,
    // data memory side
    input wire psia_pkg::psia_data_req_t memAccess,
    input wire logic [7:0] memRdata,
    input wire logic [7:0] readData,
    input wire logic readValid
);
    // one clock domain, so clock and reset are given once
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // a call followed at once by a return
    sequence callThenReturn;
        seqCmd.op == psia_pkg::OP_CALL ##1 seqCmd.op == psia_pkg::OP_RETURN;
    endsequence

    // a data request that bypasses the pointer
    sequence directReq;
        dataReq.valid && dataReq.addr[6:0] != 7'h00;
    endsequence

    a_step_advances: assert property (seqCmd.op == psia_pkg::OP_STEP |=> progAddr == $past(progAddr) + 13'h0001)
        else $error("step did not advance the counter");
    a_jump_target: assert property (seqCmd.op inside {psia_pkg::OP_GOTO, psia_pkg::OP_CALL}
        |=> progAddr[10:0] == $past(seqCmd.target))
        else $error("jump low bits differ from the target");
    a_page_masked: assert property (IGNORE_PAGE_HI && seqCmd.op inside {psia_pkg::OP_GOTO, psia_pkg::OP_CALL,
        psia_pkg::OP_WRITE_LOW} |=> !progAddr[12])
        else $error("top page bit set although ignored");
    a_low_write: assert property (seqCmd.op == psia_pkg::OP_WRITE_LOW |=> progAddr[7:0] == $past(seqCmd.low))
        else $error("low byte write not loaded");
    a_vector_jump: assert property (seqCmd.op == psia_pkg::OP_VECTOR |=> progAddr == INT_VECTOR)
        else $error("vector did not reach its address");
    a_call_return: assert property (callThenReturn |=> progAddr == $past(progAddr, 2) + 13'h0001)
        else $error("return after call lost the return address");
    a_low_readback: assert property (psel && penable && !pwrite && paddr == psia_pkg::OFF_PC_LOW
        |-> prdata == {24'h000000, progAddr[7:0]})
        else $error("low byte read wrong or upper bits visible");
    a_direct_pass: assert property (directReq |=> memAccess.valid && memAccess.addr == $past(dataReq.addr))
        else $error("direct access not passed to memory");
    a_read_answer: assert property (dataReq.valid && !dataReq.write |-> ##2 readValid)
        else $error("read not answered two cycles on");
    a_read_data: assert property (memAccess.valid && !memAccess.write |=> readData == $past(memRdata))
        else $error("read data differs from memory");
endmodule

bind psia_top psia_top_props #(.INT_VECTOR(INT_VECTOR), .IGNORE_PAGE_HI(IGNORE_PAGE_HI)) psia_top_props_inst (
    .clock, .reset, .paddr, .psel, .penable, .pwrite, .prdata, .seqCmd, .dataReq, .progAddr,
    .memAccess, .memRdata, .readData, .readValid);
`default_nettype wire

// ---- sim/psia_data_mem.sv ----
// psia_data_mem: data memory model on the far side of the block.
// assumes: reads answer in the cycle the access is shown, writes land at the edge.
`timescale 1ns/1ps
`default_nettype none
module psia_data_mem (
    // clock
    input wire logic clock,
    // access from the block
    input wire psia_pkg::psia_data_req_t memAccess,
    output logic [7:0] memRdata
);
    logic [7:0] store [512]; // one byte per data address
    logic [7:0] lastOut = 8'h00; // last value shown on the data lines

    // preset contents so unwritten reads are known
    initial begin
        for (int i = 0; i < 512; i++) begin
            store[i] = 8'(i) ^ 8'h5A;
        end
    end

    // when idle the lines toggle, so stale data never looks valid
    always_comb begin
        if (memAccess.valid && !memAccess.write) begin
            memRdata = store[memAccess.addr];
        end else begin
            memRdata = ~lastOut;
        end
    end

    // writes take effect at the edge ending the access
    always @(posedge clock) begin
        lastOut <= memRdata;
        if (memAccess.valid && memAccess.write) begin
            store[memAccess.addr] <= memAccess.wdata;
        end
    end
endmodule
`default_nettype wire

// ---- sim/psia_top_bench.sv ----
// psia_top_bench: self-checking bench for counter, stack and pointer.
// assumes: psia_top with a data memory model behind it; APB answers with no wait.
`timescale 1ns/1ps
`default_nettype none
module psia_top_bench;
    localparam logic [12:0] VEC = psia_pkg::INT_VECTOR_DEFAULT; // vector used by the instance
    logic clock = 1'b0;
    logic reset = 1'b1;
    // bus and core stimulus
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr;
    psia_pkg::psia_seq_cmd_t seqCmd = '0;
    psia_pkg::psia_data_req_t dataReq = '0;
    psia_pkg::psia_data_req_t memAccess;
    logic [12:0] progAddr;
    logic [7:0] memRdata;
    logic [7:0] readData;
    logic readValid;
    // bookkeeping
    int nErrors = 0, totalChecks = 0, cycles = 0;
    logic [7:0] expQ [$]; // expected read answers, oldest first
    logic [12:0] stk [8]; // circular model of the return stack
    logic [2:0] sp = 3'h0;
    logic [12:0] pc;
    logic [31:0] q;
    logic err;
    logic [10:0] t;

    psia_top #(.INT_VECTOR(VEC)) psia_top_inst (.clock, .reset, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .seqCmd, .dataReq, .progAddr, .memAccess, .memRdata, .readData, .readValid);
    psia_data_mem psia_data_mem_inst (.clock, .memAccess, .memRdata);

    // 200 MHz clock
    initial begin
        forever #2.5 clock = ~clock;
    end

    // compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one bus transfer; waits for pready, then releases a cycle apart
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    // one sequencer command, then an idle so the counter settles
    task automatic seq(input psia_pkg::psia_op_t op, input logic [10:0] tg, input logic [7:0] lo);
        seqCmd <= '{op, tg, lo};
        @(posedge clock);
        seqCmd <= '{psia_pkg::OP_IDLE, 11'h000, 8'h00};
        @(posedge clock);
    endtask

    // one data request per cycle; reads note their answer
    task automatic dreq(input logic wr, input logic [8:0] a, input logic [7:0] d, input logic [7:0] exp);
        dataReq <= '{1'b1, wr, a, d};
        if (!wr) expQ.push_back(exp);
        @(posedge clock);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // answer monitor, sampled away from the launching edge
    always @(negedge clock) begin
        if (readValid === 1'b1) begin
            check("readPending", 32'h1, 32'(expQ.size() != 0));
            if (expQ.size() != 0) check("readData", {24'h0, expQ.pop_front()}, {24'h0, readData});
        end
    end

    // hang guard, far above the run's length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            nErrors++;
            $display("BAD timeout expected finish seen hang");
            give_verdict();
        end
    end

    initial begin
        t = 11'($urandom(32'h2491E521));
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        check("progAddr", 32'h0, 32'(progAddr));
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check("resetValue", 32'h0, q);
            check("pslverr", 32'(i == 4), 32'(err));
        end
        $display("test reset done");
        // latch width, low byte loads with latch bits
        apb(1'b1, psia_pkg::OFF_UPPER_LATCH, 32'hFFFFFFFF);
        apb(1'b0, psia_pkg::OFF_UPPER_LATCH, 32'h0);
        check("latch", 32'h1F, q);
        seq(psia_pkg::OP_WRITE_LOW, 11'h000, 8'h3C);
        check("progAddr", 32'h0F3C, 32'(progAddr));
        apb(1'b0, psia_pkg::OFF_PC_LOW, 32'h0);
        check("pcLow", 32'h3C, q);
        apb(1'b1, psia_pkg::OFF_UPPER_LATCH, 32'h05);
        apb(1'b1, psia_pkg::OFF_PC_LOW, 32'hA7);
        check("progAddr", 32'h05A7, 32'(progAddr));
        seq(psia_pkg::OP_STEP, 11'h000, 8'h00);
        check("step", 32'h05A8, 32'(progAddr));
        $display("test low byte done");
        // every page setting with goto, call and return
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, psia_pkg::OFF_UPPER_LATCH, 32'(8 * i));
            t = 11'($urandom());
            seq(psia_pkg::OP_GOTO, t, 8'h00);
            check("goto", {20'h0, i[0], t}, 32'(progAddr));
            seq(psia_pkg::OP_CALL, ~t, 8'h00);
            check("call", {20'h0, i[0], ~t}, 32'(progAddr));
            seq(psia_pkg::OP_RETURN, 11'h000, 8'h00);
            check("return", {20'h0, i[0], t} + 32'h1, 32'(progAddr));
        end
        $display("test paging done");
        // vector then nine back-to-back calls overrun the stack
        apb(1'b1, psia_pkg::OFF_UPPER_LATCH, 32'h0A);
        stk[sp] = progAddr;
        sp++;
        seq(psia_pkg::OP_VECTOR, 11'h000, 8'h00);
        check("vector", 32'(VEC), 32'(progAddr));
        pc = VEC;
        for (int i = 0; i < 9; i++) begin
            stk[sp] = pc + 13'h1;
            sp++;
            t = 11'($urandom());
            pc = {2'b01, t};
            seqCmd <= '{psia_pkg::OP_CALL, t, 8'h00};
            @(posedge clock);
        end
        for (int i = 0; i < 10; i++) begin
            sp--;
            seq(psia_pkg::OP_RETURN, 11'h000, 8'h00);
            check("pop", 32'(stk[sp]), 32'(progAddr));
        end
        apb(1'b0, psia_pkg::OFF_UPPER_LATCH, 32'h0);
        check("latch", 32'h0A, q);
        $display("test stack done");
        // self-pointing port reads zero, write vanishes
        apb(1'b1, psia_pkg::OFF_FILE_POINTER, 32'h0);
        dreq(1'b0, 9'h080, 8'h00, 8'h00);
        dreq(1'b1, 9'h100, 8'hEE, 8'h00);
        dataReq <= '0;
        // random pointer and bank, write through the port, read back two ways
        for (int i = 0; i < 4; i++) begin
            t = 11'($urandom()) | 11'h001;
            apb(1'b1, psia_pkg::OFF_FILE_POINTER, 32'(t[7:0]));
            apb(1'b1, psia_pkg::OFF_BANK, {24'h0, t[8], 7'h00});
            dreq(1'b1, 9'h000, t[10:3], 8'h00);
            dreq(1'b0, {i[1:0], 7'h00}, 8'h00, t[10:3]);
            dreq(1'b0, t[8:0], 8'h00, t[10:3]);
            dreq(1'b0, t[8:0] ^ 9'h002, 8'h00, 8'(t[8:0] ^ 9'h002) ^ 8'h5A);
            dataReq <= '0;
            repeat (3) @(posedge clock);
        end
        check("readsLeft", 32'h0, 32'(expQ.size()));
        $display("test indirect done");
        give_verdict();
    end
endmodule
`default_nettype wire
